/* core/extended_instruction_decoder.sv */
// Functional notes
// - extended features off unless enable bit set
// - indexed offset addressing for standard instructions
// - every extended op except call through working register is pointer literal op
// - select code 3 forms act on pointer two and add automatic return; select code 2 does not return
// - add to pointer two, return, two cycles
// - subtract literal from selected pointer, one cycle
// - subtract from pointer two, return, two cycles
// - call through working register, two cycles
// - move indexed source to file address
// - move indexed source to indexed destination
// - push literal at pointer two, decrement
// - add literal to selected pointer, one cycle
`timescale 1ns/1ps
`default_nettype none
`include "ext_decoder_defs.svh"
module extended_instruction_decoder
	import ext_decoder_pkg::*;
#(
	parameter int PTR_W = 12
)
(
	input  wire logic             mclk,
	input  wire logic             rst,
	input  wire logic             ce,
	input  wire logic             extendedSetEnable,
	input  wire logic [15:0]      instrWord,
	input  wire logic             instrValid,
	input  wire logic [7:0]       workingRegister,
	input  wire logic [20:0]      topOfReturnStack,
	input  wire logic [7:0]       readData,
	output logic [PTR_W-1:0]      pointer0,
	output logic [PTR_W-1:0]      pointer1,
	output logic [PTR_W-1:0]      pointer2,
	output logic                  busy,
	output logic                  pcLoad,
	output logic [20:0]           pcTarget,
	output logic                  callPush,
	output logic                  returnPop,
	output logic                  callViaWreg,
	output logic                  memRead,
	output logic [PTR_W-1:0]      readAddr,
	output logic                  memWrite,
	output logic [PTR_W-1:0]      writeAddr,
	output logic [7:0]            writeData,
	output logic                  indexedMode,
	output logic                  secondWordNop
);
	typedef struct packed {
		exec_state_e      state;
		ext_op_e          pendingOp;
		logic [PTR_W-1:0] ptr0;
		logic [PTR_W-1:0] ptr1;
		logic [PTR_W-1:0] ptr2;
		logic [PTR_W-1:0] srcAddr;
		logic             busy;
		logic             pcLoad;
		logic [20:0]      pcTarget;
		logic             callPush;
		logic             returnPop;
		logic             callViaWreg;
		logic             memRead;
		logic [PTR_W-1:0] readAddr;
		logic             memWrite;
		logic [PTR_W-1:0] writeAddr;
		logic [7:0]       writeData;
		logic             indexedMode;
		logic             secondWordNop;
	} dec_state_s;

	dec_state_s cur;
	dec_state_s next_cur;
	ext_op_e    decodedOp;
	logic       enableSeen;

	// pointer select decode, used by add and subtract forms
	function automatic logic [PTR_W-1:0] pick_ptr(input logic [1:0] sel, input dec_state_s s);
		logic [PTR_W-1:0] v;
		v = s.ptr0;
		if (sel == 2'h1)
			v = s.ptr1;
		else if (sel == 2'h2)
			v = s.ptr2;
		return v;
	endfunction

	function automatic logic [PTR_W-1:0] lit6(input logic [15:0] w);
		return {{(PTR_W-6){1'b0}}, w[5:0]};
	endfunction

	function automatic logic [PTR_W-1:0] lit7(input logic [15:0] w);
		return {{(PTR_W-7){1'b0}}, w[6:0]};
	endfunction

	// enable gating
	// config bit is static; gate decode with it so reset state stays standard
	assign enableSeen = extendedSetEnable;

	ext_word_classifier classifier
	(
		.word   (instrWord),
		.enable (enableSeen),
		.op     (decodedOp)
	);

	always_comb
	begin
		logic [PTR_W-1:0] sel;
		sel = '0;
		next_cur = cur;
		next_cur.pcLoad = 1'b0;
		next_cur.callPush = 1'b0;
		next_cur.returnPop = 1'b0;
		next_cur.callViaWreg = 1'b0;
		next_cur.memRead = 1'b0;
		next_cur.memWrite = 1'b0;
		next_cur.secondWordNop = 1'b0;
		// indexed literal offset
		// standard byte ops with a=0 and addr below 0x60 index off pointer two
		next_cur.indexedMode = enableSeen;
		unique case (cur.state)
			ST_DECODE:
			begin
				next_cur.busy = 1'b0;
				if (instrValid)
				begin
					if (instrWord[15:12] == `OPC_PREFIX_SECOND)
						next_cur.secondWordNop = 1'b1;
					unique case (decodedOp)
						OP_ADD_POINTER:
						begin
							sel = pick_ptr(instrWord[7:6], cur);
							sel = PTR_W'(sel + lit6(instrWord));
							if (instrWord[7:6] == 2'h0)
								next_cur.ptr0 = sel;
							else if (instrWord[7:6] == 2'h1)
								next_cur.ptr1 = sel;
							else
								next_cur.ptr2 = sel;
						end
						OP_SUB_POINTER:
						begin
							sel = pick_ptr(instrWord[7:6], cur);
							sel = PTR_W'(sel - lit6(instrWord));
							if (instrWord[7:6] == 2'h0)
								next_cur.ptr0 = sel;
							else if (instrWord[7:6] == 2'h1)
								next_cur.ptr1 = sel;
							else
								next_cur.ptr2 = sel;
						end
						OP_ADD_RETURN, OP_SUB_RETURN:
						begin
							if (decodedOp == OP_ADD_RETURN)
								next_cur.ptr2 = PTR_W'(cur.ptr2 + lit6(instrWord));
							else
								next_cur.ptr2 = PTR_W'(cur.ptr2 - lit6(instrWord));
							next_cur.pcLoad = 1'b1;
							next_cur.pcTarget = topOfReturnStack;
							next_cur.returnPop = 1'b1;
							next_cur.busy = 1'b1;
							next_cur.state = ST_FILL;
						end
						OP_CALL_WORKING_REGISTER:
						begin
							next_cur.callPush = 1'b1;
							next_cur.callViaWreg = 1'b1;
							next_cur.pcLoad = 1'b1;
							next_cur.pcTarget = {cur.pcTarget[20:8], workingRegister};
							next_cur.busy = 1'b1;
							next_cur.state = ST_FILL;
						end
						OP_PUSH_LITERAL:
						begin
							next_cur.memWrite = 1'b1;
							next_cur.writeAddr = cur.ptr2;
							next_cur.writeData = instrWord[7:0];
							next_cur.ptr2 = PTR_W'(cur.ptr2 - PTR_W'(1));
						end
						OP_MOVE_TO_FILE, OP_MOVE_TO_INDEXED:
						begin
							next_cur.srcAddr = PTR_W'(cur.ptr2 + lit7(instrWord));
							next_cur.memRead = 1'b1;
							next_cur.readAddr = PTR_W'(cur.ptr2 + lit7(instrWord));
							next_cur.pendingOp = decodedOp;
							next_cur.busy = 1'b1;
							next_cur.state = ST_SECOND_WORD;
						end
						default:
						begin
						end
					endcase
				end
			end
			ST_SECOND_WORD:
			begin
				if (instrValid)
				begin
					next_cur.memWrite = 1'b1;
					next_cur.writeData = readData;
					if (cur.pendingOp == OP_MOVE_TO_FILE)
						next_cur.writeAddr = PTR_W'(instrWord[11:0]);
					else
						next_cur.writeAddr = PTR_W'(cur.ptr2 + lit7(instrWord));
					next_cur.pendingOp = OP_NONE;
					next_cur.busy = 1'b0;
					next_cur.state = ST_DECODE;
				end
			end
			ST_FILL:
			begin
				// second cycle executes as a no-operation
				next_cur.busy = 1'b0;
				next_cur.state = ST_DECODE;
			end
			default:
			begin
				// unused state code: drop any pending move, resume decoding
				next_cur.pendingOp = OP_NONE;
				next_cur.busy = 1'b0;
				next_cur.state = ST_DECODE;
			end
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			cur <= '0;
			cur.state <= ST_DECODE;
			cur.pendingOp <= OP_NONE;
			cur.ptr0 <= `PTR_RESET;
			cur.ptr1 <= `PTR_RESET;
			cur.ptr2 <= `PTR_RESET;
		end
		else if (ce)
			cur <= next_cur;
	end

	assign pointer0 = cur.ptr0;
	assign pointer1 = cur.ptr1;
	assign pointer2 = cur.ptr2;
	assign busy = cur.busy;
	assign pcLoad = cur.pcLoad;
	assign pcTarget = cur.pcTarget;
	assign callPush = cur.callPush;
	assign returnPop = cur.returnPop;
	assign callViaWreg = cur.callViaWreg;
	assign memRead = cur.memRead;
	assign readAddr = cur.readAddr;
	assign memWrite = cur.memWrite;
	assign writeAddr = cur.writeAddr;
	assign writeData = cur.writeData;
	assign indexedMode = cur.indexedMode;
	assign secondWordNop = cur.secondWordNop;
endmodule
`default_nettype wire

/* core/ext_decoder_defs.svh */
`ifndef EXT_DECODER_DEFS_SVH
`define EXT_DECODER_DEFS_SVH
`define OPC_PREFIX_EXT      4'hE
`define OPC_PREFIX_SECOND   4'hF
`define OPC_ADD_POINTER     4'h8
`define OPC_SUB_POINTER     4'h9
`define OPC_PUSH_LITERAL    4'hA
`define OPC_MOVE_INDEXED    4'hB
`define OPC_CALL_WORKING_REGISTER       16'h0014
`define PTR_SEL_TWO         2'h3
`define PTR_RESET           12'h000
`define CYCLES_RETURN_FORM  2
`define CYCLES_CALL         2
`define CYCLES_MOVE         2
`endif

/* core/ext_decoder_pkg.sv */
package ext_decoder_pkg;
	typedef enum logic [3:0] {
		OP_NONE,
		OP_ADD_POINTER,
		OP_ADD_RETURN,
		OP_SUB_POINTER,
		OP_SUB_RETURN,
		OP_CALL_WORKING_REGISTER,
		OP_MOVE_TO_FILE,
		OP_MOVE_TO_INDEXED,
		OP_PUSH_LITERAL
	} ext_op_e;
	typedef enum logic [1:0] {
		ST_DECODE,
		ST_SECOND_WORD,
		ST_FILL
	} exec_state_e;
endpackage

/* core/ext_word_classifier.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ext_decoder_defs.svh"
module ext_word_classifier
	import ext_decoder_pkg::*;
(
	input  wire logic [15:0] word,
	input  wire logic        enable,
	output ext_op_e          op
);
	always_comb
	begin
		op = OP_NONE;
		if (enable)
		begin
			if (word == `OPC_CALL_WORKING_REGISTER)
				op = OP_CALL_WORKING_REGISTER;
			else if (word[15:12] == `OPC_PREFIX_EXT)
			begin
				unique case (word[11:8])
					`OPC_ADD_POINTER:
						op = (word[7:6] == `PTR_SEL_TWO) ? OP_ADD_RETURN : OP_ADD_POINTER;
					`OPC_SUB_POINTER:
						op = (word[7:6] == `PTR_SEL_TWO) ? OP_SUB_RETURN : OP_SUB_POINTER;
					`OPC_PUSH_LITERAL:
						op = OP_PUSH_LITERAL;
					`OPC_MOVE_INDEXED:
						op = word[7] ? OP_MOVE_TO_INDEXED : OP_MOVE_TO_FILE;
					default:
						op = OP_NONE;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

/* test/extended_instruction_decoder_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module extended_instruction_decoder_properties
	import ext_decoder_pkg::*;
#(
	parameter int PTR_W = 12
)
(
	input wire logic             mclk,
	input wire logic             rst,
	input wire logic             ce,
	input wire logic             extendedSetEnable,
	input wire logic [15:0]      instrWord,
	input wire logic             instrValid,
	input wire logic [PTR_W-1:0] pointer0,
	input wire logic [PTR_W-1:0] pointer2,
	input wire logic             busy,
	input wire logic             pcLoad,
	input wire logic             returnPop,
	input wire logic             callViaWreg,
	input wire logic             memRead,
	input wire logic [PTR_W-1:0] readAddr,
	input wire logic             memWrite,
	input wire logic [PTR_W-1:0] writeAddr,
	input wire logic             indexedMode,
	input wire logic             secondWordNop
);
	logic take;
	logic takeExt;
	// words offered while busy are fill or second words, not new ops
	assign take = ce && instrValid && !busy;
	assign takeExt = take && extendedSetEnable;
	default clocking dc @(posedge mclk);
	endclocking
	default disable iff (rst);
	gate_off_a: assert property (take && !extendedSetEnable && instrWord[15:12] == 4'hE
		|=> !pcLoad && !memWrite && !memRead && $stable(pointer2)) else $error("op ran while off");
	add_ret_a: assert property (takeExt && instrWord[15:6] == 10'h3A3
		|=> pcLoad && returnPop && busy && pointer2 == $past(pointer2) + $past(instrWord[5:0])) else $error("add return");
	sub_ret_a: assert property (takeExt && instrWord[15:6] == 10'h3A7
		|=> pcLoad && returnPop && busy && pointer2 == $past(pointer2) - $past(instrWord[5:0])) else $error("sub return");
	add_ptr_a: assert property (takeExt && instrWord[15:6] == 10'h3A0
		|=> !busy && pointer0 == $past(pointer0) + $past(instrWord[5:0])) else $error("add pointer");
	call_working_register_a: assert property (takeExt && instrWord == 16'h0014
		|=> callViaWreg && pcLoad && busy ##1 !busy) else $error("call timing");
	push_lit_a: assert property (takeExt && instrWord[15:8] == 8'hEA
		|=> memWrite && writeAddr == $past(pointer2) && pointer2 == $past(pointer2) - 1'b1) else $error("push");
	move_read_a: assert property (takeExt && instrWord[15:8] == 8'hEB
		|=> memRead && busy && readAddr == $past(pointer2) + $past(instrWord[6:0])) else $error("move read");
	stray_nop_a: assert property (takeExt && instrWord[15:12] == 4'hF
		|=> secondWordNop && !memWrite) else $error("stray word");
	index_flag_a: assert property ($past(ce) && !$past(rst)
		|-> indexedMode == $past(extendedSetEnable)) else $error("index flag");
	cover property (takeExt && instrWord[15:6] == 10'h3A3);
	cover property (memRead ##1 memWrite);
	cover property (secondWordNop);
endmodule
bind extended_instruction_decoder extended_instruction_decoder_properties #(.PTR_W(PTR_W)) chk_u (
	.mclk(mclk), .rst(rst), .ce(ce), .extendedSetEnable(extendedSetEnable), .instrWord(instrWord),
	.instrValid(instrValid), .pointer0(pointer0), .pointer2(pointer2), .busy(busy), .pcLoad(pcLoad),
	.returnPop(returnPop), .callViaWreg(callViaWreg), .memRead(memRead), .readAddr(readAddr),
	.memWrite(memWrite), .writeAddr(writeAddr), .indexedMode(indexedMode), .secondWordNop(secondWordNop)
);
`default_nettype wire

/* test/test_extended_instruction_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
module test_extended_instruction_decoder;
	typedef struct packed {
		logic [15:0] w;
		logic [11:0] p0;
		logic [11:0] p1;
		logic [11:0] p2;
	} row_s;
	row_s        rows [6] = '{'{16'hE805, 12'h5, 12'h0, 12'h0}, '{16'hE84A, 12'h5, 12'hA, 12'h0},
		'{16'hE8BF, 12'h5, 12'hA, 12'h3F}, '{16'hE901, 12'h4, 12'hA, 12'h3F},
		'{16'hE942, 12'h4, 12'h8, 12'h3F}, '{16'hE981, 12'h4, 12'h8, 12'h3E}};
	logic        mclk = 1'h0;
	logic        rst = 1'h1;
	logic        ce = 1'h1;
	logic        extendedSetEnable = 1'h1;
	logic        instrValid = 1'h0;
	logic [15:0] instrWord = 16'h0;
	logic [7:0]  workingRegister = 8'h0;
	logic [7:0]  readData = 8'h0;
	logic [20:0] topOfReturnStack = 21'h0;
	logic [11:0] pointer0, pointer1, pointer2, readAddr, writeAddr;
	logic [20:0] pcTarget;
	logic [7:0]  writeData;
	logic        busy, pcLoad, callPush, returnPop, callViaWreg, memRead, memWrite, indexedMode, secondWordNop;
	int          numErrors = 0;
	int          checksDone = 0;
	extended_instruction_decoder dut_u (
		.mclk(mclk), .rst(rst), .ce(ce), .extendedSetEnable(extendedSetEnable), .instrWord(instrWord),
		.instrValid(instrValid), .workingRegister(workingRegister), .topOfReturnStack(topOfReturnStack),
		.readData(readData), .pointer0(pointer0), .pointer1(pointer1), .pointer2(pointer2), .busy(busy),
		.pcLoad(pcLoad), .pcTarget(pcTarget), .callPush(callPush), .returnPop(returnPop),
		.callViaWreg(callViaWreg), .memRead(memRead), .readAddr(readAddr), .memWrite(memWrite),
		.writeAddr(writeAddr), .writeData(writeData), .indexedMode(indexedMode), .secondWordNop(secondWordNop)
	);
	always #2.5 mclk = ~mclk;
	task chk(input logic [20:0] got, input logic [20:0] exp);
		checksDone++;
		if (got !== exp)
		begin
			numErrors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// valid stays up so back-to-back words need no gap
	task op(input logic [15:0] w);
		instrWord = w;
		instrValid = 1'h1;
		@(posedge mclk);
		#1;
	endtask
	task idle;
		instrValid = 1'h0;
		@(posedge mclk);
		#1;
	endtask
	task summarize;
		$display("errors %0d checks %0d", numErrors, checksDone);
		if (numErrors == 0 && checksDone > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial
	begin
		repeat (8) @(posedge mclk);
		#1;
		rst = 1'h0;
		chk(pointer2, 12'h0);
		chk(busy, 1'h0);
		foreach (rows[i])
		begin
			op(rows[i].w);
			chk(pointer0, rows[i].p0);
			chk(pointer1, rows[i].p1);
			chk(pointer2, rows[i].p2);
		end
		chk(indexedMode, 1'h1);
		op(16'hEA77);
		chk(writeAddr, 12'h3E);
		chk(memWrite, 1'h1);
		chk(writeData, 8'h77);
		chk(pointer2, 12'h3D);
		topOfReturnStack = 21'h12345;
		op(16'hE8C5);
		chk(returnPop, 1'h1);
		chk(pcTarget, 21'h12345);
		chk(pcLoad, 1'h1);
		chk(busy, 1'h1);
		chk(pointer2, 12'h42);
		op(16'hE801);
		chk(pointer0, 12'h4);
		op(16'hE9C2);
		chk(returnPop, 1'h1);
		chk(pointer2, 12'h40);
		idle;
		workingRegister = 8'h5A;
		op(16'h0014);
		chk(callPush, 1'h1);
		chk(pcTarget[7:0], 8'h5A);
		idle;
		op(16'hEB05);
		chk(readAddr, 12'h45);
		chk(memRead, 1'h1);
		readData = 8'h3C;
		op(16'hF123);
		chk(writeAddr, 12'h123);
		chk(writeData, 8'h3C);
		chk(memWrite, 1'h1);
		chk(busy, 1'h0);
		op(16'hEB83);
		chk(readAddr, 12'h43);
		readData = 8'h99;
		op(16'hFF87);
		chk(writeAddr, 12'h47);
		chk(writeData, 8'h99);
		op(16'hF123);
		chk(secondWordNop, 1'h1);
		ce = 1'h0;
		op(16'hE805);
		chk(pointer0, 12'h4);
		ce = 1'h1;
		extendedSetEnable = 1'h0;
		op(16'hE805);
		chk(pointer0, 12'h4);
		chk(indexedMode, 1'h0);
		op(16'h0014);
		chk(callViaWreg, 1'h0);
		idle;
		rst = 1'h1;
		idle;
		rst = 1'h0;
		chk(pointer0, 12'h0);
		chk(pointer2, 12'h0);
		chk(busy, 1'h0);
		summarize;
	end
endmodule
`default_nettype wire
